// file: hw/udm_pkg.sv
// Shared constants for both ends
package udm_pkg;
   localparam int DATA_W       = 8;
   localparam int FIFO_DEPTH   = 3;
   localparam int BIT_CYCLES   = 16;
   localparam int ADDR_W       = 6;

   // Register indices; byte address is four times the index
   localparam logic [3:0] REG_MODE_ONE = 4'h0;
   localparam logic [3:0] REG_MODE_TWO = 4'h1;
   localparam logic [3:0] REG_STATUS   = 4'h2;
   localparam logic [3:0] REG_RX_DATA  = 4'h3;
   localparam logic [3:0] REG_TX_DATA  = 4'h4;
   localparam logic [3:0] REG_COMMAND  = 4'h5;
   localparam logic [3:0] REG_IN_CHG   = 4'h6;
   localparam logic [3:0] REG_OUT_PORT = 4'h7;
   localparam logic [3:0] REG_OP_SET   = 4'hE;
   localparam logic [3:0] REG_OP_CLR   = 4'hF;

   localparam int MR1_RX_RTS = 7;
   localparam int MR1_PAR_HI = 4;
   localparam int MR1_PAR_LO = 3;
   localparam int MR1_SEL    = 2;
   localparam int MR2_TX_RTS = 5;
   localparam int MR2_CTS_EN = 4;

   localparam int SR_RX_CHAR_AVAILABLE = 0;
   localparam int SR_RX_FIFO_FULL_FLAG = 1;
   localparam int SR_TXRDY = 2;
   localparam int SR_TXEMT = 3;
   localparam int SR_OE    = 4;
   localparam int SR_PE    = 5;
   localparam int SR_FE    = 6;

   localparam int OPR_RTS     = 0;
   localparam int OPR_CTS_OUT = 3;
   localparam int IPC_LEVEL   = 2;
   localparam int IPC_DELTA   = 6;

   localparam int CMD_RX_EN   = 0;
   localparam int CMD_TX_EN   = 1;
   localparam int CMD_RST_ERR = 2;

   localparam logic [1:0] PAR_WITH  = 2'h0;
   localparam logic [1:0] PAR_FORCE = 2'h1;
   localparam logic [1:0] PAR_NONE  = 2'h2;
   localparam logic [1:0] PAR_MULTI = 2'h3;

   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [7:0] REG_RST   = 8'h00;

   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_BITS} udm_ser_e;

   // Bit after the data
   function automatic logic udm_extra_bit(input logic [1:0] mode, input logic sel,
                                          input logic [7:0] data);
      if (mode == PAR_WITH)
         return sel ? ~(^data) : (^data);
      else if (mode == PAR_NONE)
         return 1'b0;
      else
         return sel;
   endfunction

   function automatic logic udm_has_extra(input logic [1:0] mode);
      return mode != PAR_NONE;
   endfunction
endpackage

// file: hw/udm_link_if.sv
// Link wires between both ends
`timescale 1ns/10ps
interface udm_link_if;
   logic dev_serial_out;
   logic chan_a_serial_input;
   logic chan_a_request_to_send_n;
   logic output_pin_three_n;
   logic input_pin_two;
   logic chan_a_clear_to_send_n;

   modport dev (
      output dev_serial_out,
      output chan_a_request_to_send_n,
      output output_pin_three_n,
      input  chan_a_serial_input,
      input  input_pin_two,
      input  chan_a_clear_to_send_n
   );

   modport far (
      input  dev_serial_out,
      input  chan_a_request_to_send_n,
      input  output_pin_three_n,
      output chan_a_serial_input,
      output input_pin_two,
      output chan_a_clear_to_send_n
   );
endinterface

// file: hw/udm_duart_end.sv
// Controller channel with flow control and multidrop
// What this block and its host do
// R1: Transfer into receive FIFO sets character-available.
// R2: Only reading the last character clears it.
// R3: Receive errors show in status, never interrupt.
// R4: Host checks status for every received character.
// R5: Receiver RTS mode negates RTS when FIFO full.
// R6: Output port bit zero drives RTS low.
// R7: Write to set address sets chosen bits.
// R8: Write to clear address clears chosen bits.
// R9: RTS not reasserted automatically; host sets again.
// R10: CTS gating holds transmitter while CTS negated.
// R11: Transmitter RTS mode negates one bit after empty.
// R12: Input two change flagged; level reported.
// R13: Host mirrors input two onto output three.
// R14: Multidrop appends address/data flag after data.
// R15: Flag one means address, zero data.
// R16: Address characters reach host even when disabled.
// R17: Disabled receiver drops data until next address.
// R18: Master sends target address before data block.
// R19: Full flag on third entry, cleared on read.
// R20: Parity field value three selects multidrop.
// R21: Sent flag equals mode one select bit.
// R22: Received flag shown in parity error slot.
// R23: RTS and CTS are active low.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module udm_duart_end #(
   parameter int BIT_CYCLES = udm_pkg::BIT_CYCLES,
   parameter int DEPTH      = udm_pkg::FIFO_DEPTH
) (
   input  wire logic                        core_clk,
   input  wire logic                        arst_n,
   udm_link_if.dev                          link,
   input  wire logic [udm_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   input  wire logic [3:0]                  avs_byteenable,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   output logic                             rx_fifo_full
);
   localparam int CW   = $clog2(BIT_CYCLES);
   localparam int CNTW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0]   BIT_LAST  = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0]   HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
   localparam logic [CNTW-1:0] FULL_CNT  = CNTW'(DEPTH);

   typedef struct packed {
      logic [7:0]             mode_one;
      logic [7:0]             mode_two;
      logic [7:0]             output_port_register;
      logic                   rx_en;
      logic                   tx_en;
      logic                   overrun;
      logic                   in_delta;
      logic [1:0]             rxd_sy;
      logic [1:0]             cts_sy;
      logic [1:0]             ip2_sy;
      logic                   ip2_last;
      udm_pkg::udm_ser_e      rx_st;
      logic [CW-1:0]          rx_cnt;
      logic [3:0]             rx_idx;
      logic [8:0]             rx_sh;
      logic                   rsr_valid;
      logic [7:0]             rsr_data;
      logic                   rsr_flag;
      logic                   rsr_fe;
      logic [DEPTH-1:0][7:0]  fifo_data;
      logic [DEPTH-1:0]       fifo_flag;
      logic [DEPTH-1:0]       fifo_fe;
      logic [CNTW-1:0]        fifo_count;
      logic                   rx_fifo_full_flag;
      logic [7:0]             tx_holding_register;
      logic                   thr_flag;
      logic                   thr_valid;
      udm_pkg::udm_ser_e      tx_st;
      logic [CW-1:0]          tx_cnt;
      logic [3:0]             tx_idx;
      logic [10:0]            tx_sh;
      logic                   txemt;
      logic                   rts_arm;
      logic [CW-1:0]          rts_cnt;
      logic                   rd_ack;
      logic [7:0]             rdata;
   } udm_dev_s;

   udm_dev_s   s_q;
   udm_dev_s   s_d;
   logic [1:0] par;
   logic       has;
   logic [3:0] idx;
   logic       wr;
   logic       rd_go;
   logic [7:0] wbyte;
   logic [7:0] status;
   logic [7:0] rx_byte;
   logic       rx_x;
   logic       rx_keep;

   always_comb begin
      s_d     = s_q;
      par     = s_q.mode_one[udm_pkg::MR1_PAR_HI:udm_pkg::MR1_PAR_LO];  // R20
      has     = udm_pkg::udm_has_extra(par);
      idx     = avs_address[udm_pkg::ADDR_W-1:2];
      wr      = avs_write & avs_byteenable[0];
      rd_go   = avs_read & s_q.rd_ack;
      wbyte   = avs_writedata[7:0];
      rx_byte = 8'h00;
      rx_x    = 1'b0;
      rx_keep = 1'b0;
      s_d.rxd_sy = {s_q.rxd_sy[0], link.chan_a_serial_input};
      s_d.cts_sy = {s_q.cts_sy[0], link.chan_a_clear_to_send_n};
      s_d.ip2_sy = {s_q.ip2_sy[0], link.input_pin_two};

      // Parity and framing bits follow the FIFO head
      status = 8'h00;
      status[udm_pkg::SR_RX_CHAR_AVAILABLE] = s_q.fifo_count != '0;  // R1 R2 R16
      status[udm_pkg::SR_RX_FIFO_FULL_FLAG] = s_q.rx_fifo_full_flag;
      status[udm_pkg::SR_TXRDY] = s_q.tx_en & ~s_q.thr_valid;
      status[udm_pkg::SR_TXEMT] = s_q.txemt;
      status[udm_pkg::SR_OE]    = s_q.overrun;  // R3 R4
      status[udm_pkg::SR_PE]    = status[udm_pkg::SR_RX_CHAR_AVAILABLE] & s_q.fifo_flag[0];  // R3 R22
      status[udm_pkg::SR_FE]    = status[udm_pkg::SR_RX_CHAR_AVAILABLE] & s_q.fifo_fe[0];  // R3

      // One wait state: read data from a flop
      s_d.rd_ack = avs_read & ~s_q.rd_ack;
      if (avs_read & ~s_q.rd_ack) begin
         unique case (idx)
            udm_pkg::REG_MODE_ONE: s_d.rdata = s_q.mode_one;
            udm_pkg::REG_MODE_TWO: s_d.rdata = s_q.mode_two;
            udm_pkg::REG_STATUS:   s_d.rdata = status;
            udm_pkg::REG_RX_DATA:  s_d.rdata = s_q.fifo_data[0];
            udm_pkg::REG_COMMAND:  s_d.rdata = {5'h00, 1'b0, s_q.tx_en, s_q.rx_en};
            udm_pkg::REG_IN_CHG: begin
               s_d.rdata = 8'h00;
               s_d.rdata[udm_pkg::IPC_LEVEL] = s_q.ip2_last;  // R12
               s_d.rdata[udm_pkg::IPC_DELTA] = s_q.in_delta;
            end
            udm_pkg::REG_OUT_PORT: s_d.rdata = s_q.output_port_register;
            default:               s_d.rdata = 8'h00;
         endcase
      end
      if (rd_go && idx == udm_pkg::REG_RX_DATA && s_q.fifo_count != '0) begin
         s_d.fifo_data  = {8'h00, s_q.fifo_data[DEPTH-1:1]};
         s_d.fifo_flag  = {1'b0, s_q.fifo_flag[DEPTH-1:1]};
         s_d.fifo_fe    = {1'b0, s_q.fifo_fe[DEPTH-1:1]};
         s_d.fifo_count = s_q.fifo_count - CNTW'(1);  // R2
         s_d.rx_fifo_full_flag      = 1'b0;  // R19
      end
      if (rd_go && idx == udm_pkg::REG_IN_CHG)
         s_d.in_delta = 1'b0;

      if (wr) begin
         unique case (idx)
            udm_pkg::REG_MODE_ONE: s_d.mode_one = wbyte;
            udm_pkg::REG_MODE_TWO: s_d.mode_two = wbyte;
            udm_pkg::REG_COMMAND: begin
               s_d.rx_en = wbyte[udm_pkg::CMD_RX_EN];
               s_d.tx_en = wbyte[udm_pkg::CMD_TX_EN];
               if (wbyte[udm_pkg::CMD_RST_ERR])
                  s_d.overrun = 1'b0;
               if (!wbyte[udm_pkg::CMD_TX_EN]) begin
                  s_d.thr_valid = 1'b0;
                  s_d.txemt     = 1'b0;
               end
            end
            udm_pkg::REG_TX_DATA: if (s_q.tx_en) begin
               s_d.tx_holding_register       = wbyte;
               s_d.thr_flag  = udm_pkg::udm_extra_bit(par, s_q.mode_one[udm_pkg::MR1_SEL],
                                                     wbyte);  // R14 R15 R21
               s_d.thr_valid = 1'b1;
               s_d.txemt     = 1'b0;
            end
            udm_pkg::REG_OP_SET:
               s_d.output_port_register = s_q.output_port_register | wbyte;  // R7 R9
            udm_pkg::REG_OP_CLR:
               s_d.output_port_register = s_q.output_port_register & ~wbyte;  // R8
            default: ;
         endcase
      end

      // Sticky; a change beats the clearing read
      if (s_q.ip2_sy[1] != s_q.ip2_last)
         s_d.in_delta = 1'b1;  // R12
      s_d.ip2_last = s_q.ip2_sy[1];

      if (s_q.rsr_valid && s_d.fifo_count != FULL_CNT) begin
         s_d.fifo_data[s_d.fifo_count] = s_q.rsr_data;
         s_d.fifo_flag[s_d.fifo_count] = s_q.rsr_flag;
         s_d.fifo_fe[s_d.fifo_count]   = s_q.rsr_fe;
         s_d.fifo_count = s_d.fifo_count + CNTW'(1);  // R1
         s_d.rsr_valid  = 1'b0;
         if (s_d.fifo_count == FULL_CNT)
            s_d.rx_fifo_full_flag = 1'b1;  // R19
      end

      unique case (s_q.rx_st)
         udm_pkg::SER_IDLE: if (!s_q.rxd_sy[1]) begin
            s_d.rx_st  = udm_pkg::SER_START;
            s_d.rx_cnt = HALF_LAST;
         end
         udm_pkg::SER_START: begin
            if (s_q.rx_cnt != '0)
               s_d.rx_cnt = s_q.rx_cnt - CW'(1);
            else if (!s_q.rxd_sy[1]) begin
               s_d.rx_st  = udm_pkg::SER_BITS;
               s_d.rx_cnt = BIT_LAST;
               s_d.rx_idx = 4'h0;
            end else
               s_d.rx_st = udm_pkg::SER_IDLE;
         end
         udm_pkg::SER_BITS: begin
            if (s_q.rx_cnt != '0)
               s_d.rx_cnt = s_q.rx_cnt - CW'(1);
            else if (s_q.rx_idx != DATA_BITS_PLUS(has)) begin
               s_d.rx_sh  = {s_q.rxd_sy[1], s_q.rx_sh[8:1]};
               s_d.rx_idx = s_q.rx_idx + 4'h1;
               s_d.rx_cnt = BIT_LAST;
            end else begin
               rx_byte = has ? s_q.rx_sh[7:0] : s_q.rx_sh[8:1];
               rx_x    = has & s_q.rx_sh[8];
               // Disabled multidrop still takes addresses
               rx_keep = s_q.rx_en | (par == udm_pkg::PAR_MULTI && rx_x);  // R16 R17 R22
               if (rx_keep) begin
                  if (s_d.rsr_valid)
                     s_d.overrun = 1'b1;  // R3
                  s_d.rsr_valid = 1'b1;
                  s_d.rsr_data  = rx_byte;
                  s_d.rsr_fe    = ~s_q.rxd_sy[1];
                  s_d.rsr_flag  = (par == udm_pkg::PAR_MULTI) ? rx_x :
                                  has & (rx_x != udm_pkg::udm_extra_bit(par,
                                  s_q.mode_one[udm_pkg::MR1_SEL], rx_byte));  // R22
               end
               s_d.rx_st = udm_pkg::SER_IDLE;
            end
         end
         default: s_d.rx_st = udm_pkg::SER_IDLE;
      endcase

      unique case (s_q.tx_st)
         udm_pkg::SER_BITS: begin
            if (s_q.tx_cnt != '0)
               s_d.tx_cnt = s_q.tx_cnt - CW'(1);
            else begin
               s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
               if (s_q.tx_idx == DATA_BITS_PLUS(has) + 4'h1) begin
                  s_d.tx_st = udm_pkg::SER_IDLE;
                  s_d.txemt = ~s_d.thr_valid;
               end else begin
                  s_d.tx_idx = s_q.tx_idx + 4'h1;
                  s_d.tx_cnt = BIT_LAST;
               end
            end
         end
         default: begin
            if (s_q.thr_valid && s_q.tx_en &&
                (!s_q.mode_two[udm_pkg::MR2_CTS_EN] || !s_q.cts_sy[1])) begin  // R10 R23
               s_d.tx_sh = has ? {1'b1, s_q.thr_flag, s_q.tx_holding_register, 1'b0} :
                                 {2'h3, s_q.tx_holding_register, 1'b0};  // R14
               s_d.tx_st     = udm_pkg::SER_BITS;
               s_d.tx_idx    = 4'h0;
               s_d.tx_cnt    = BIT_LAST;
               s_d.thr_valid = 1'b0;
               s_d.rts_arm   = 1'b1;
               s_d.rts_cnt   = BIT_LAST;
            end
         end
      endcase

      // One bit after both registers run dry
      if (s_q.tx_st == udm_pkg::SER_IDLE && !s_q.thr_valid && s_q.rts_arm &&
          s_q.mode_two[udm_pkg::MR2_TX_RTS]) begin
         if (s_q.rts_cnt != '0)
            s_d.rts_cnt = s_q.rts_cnt - CW'(1);
         else begin
            s_d.output_port_register[udm_pkg::OPR_RTS] = 1'b0;  // R11
            s_d.rts_arm = 1'b0;
         end
      end
      // Level while full; host must set again
      if (s_q.mode_one[udm_pkg::MR1_RX_RTS] && s_d.rx_fifo_full_flag)
         s_d.output_port_register[udm_pkg::OPR_RTS] = 1'b0;  // R5 R9
   end

   function automatic logic [3:0] DATA_BITS_PLUS(input logic extra);
      return udm_pkg::DATA_BITS + {3'h0, extra};
   endfunction

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q          <= '0;
         s_q.tx_sh    <= '1;
         s_q.rxd_sy   <= '1;
         s_q.cts_sy   <= '1;
         s_q.ip2_sy   <= '1;
         s_q.ip2_last <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.dev_serial_out           = s_q.tx_sh[0];
   assign link.chan_a_request_to_send_n = ~s_q.output_port_register[udm_pkg::OPR_RTS];  // R6 R23
   assign link.output_pin_three_n       = ~s_q.output_port_register[udm_pkg::OPR_CTS_OUT];
   assign avs_readdata                  = {24'h000000, s_q.rdata};
   assign avs_waitrequest               = avs_read & ~s_q.rd_ack;
   assign rx_fifo_full                  = s_q.rx_fifo_full_flag;
endmodule

// file: hw/udm_peer_end.sv
// Remote serial station
`timescale 1ns/10ps
module udm_peer_end #(
   parameter int BIT_CYCLES = udm_pkg::BIT_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   udm_link_if.far         link,
   input  wire logic       nine_bit,
   input  wire logic       cts_gate_en,
   input  wire logic       rts_assert,
   input  wire logic       cts_out_assert,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_flag,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic [7:0]      rx_data,
   output logic            rx_flag,
   output logic            rx_frame_err,
   output logic            rx_valid,
   output logic            cts_in_n
);
   localparam int CW = $clog2(BIT_CYCLES);
   localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);

   typedef struct packed {
      logic [1:0]        rxd_sy;
      logic [1:0]        gate_sy;
      logic [1:0]        op3_sy;
      logic              rts_n;
      logic              cts_out_n;
      udm_pkg::udm_ser_e rx_st;
      logic [CW-1:0]     rx_cnt;
      logic [3:0]        rx_idx;
      logic [8:0]        rx_sh;
      logic [7:0]        rx_data;
      logic              rx_flag;
      logic              rx_fe;
      logic              rx_valid;
      udm_pkg::udm_ser_e tx_st;
      logic [CW-1:0]     tx_cnt;
      logic [3:0]        tx_idx;
      logic [10:0]       tx_sh;
   } udm_peer_s;

   udm_peer_s  s_q;
   udm_peer_s  s_d;
   logic [3:0] last_idx;

   assign last_idx = udm_pkg::DATA_BITS + {3'h0, nine_bit};
   assign tx_ready = (s_q.tx_st == udm_pkg::SER_IDLE) & (~cts_gate_en | ~s_q.gate_sy[1]);

   always_comb begin
      s_d           = s_q;
      s_d.rxd_sy    = {s_q.rxd_sy[0], link.dev_serial_out};
      s_d.gate_sy   = {s_q.gate_sy[0], link.chan_a_request_to_send_n};
      s_d.op3_sy    = {s_q.op3_sy[0], link.output_pin_three_n};
      s_d.rts_n     = ~rts_assert;
      s_d.cts_out_n = ~cts_out_assert;  // R13
      s_d.rx_valid  = 1'b0;

      unique case (s_q.rx_st)
         udm_pkg::SER_IDLE: if (!s_q.rxd_sy[1]) begin
            s_d.rx_st  = udm_pkg::SER_START;
            s_d.rx_cnt = HALF_LAST;
         end
         udm_pkg::SER_START: begin
            if (s_q.rx_cnt != '0)
               s_d.rx_cnt = s_q.rx_cnt - CW'(1);
            else if (!s_q.rxd_sy[1]) begin
               s_d.rx_st  = udm_pkg::SER_BITS;
               s_d.rx_cnt = BIT_LAST;
               s_d.rx_idx = 4'h0;
            end else
               s_d.rx_st = udm_pkg::SER_IDLE;
         end
         udm_pkg::SER_BITS: begin
            if (s_q.rx_cnt != '0)
               s_d.rx_cnt = s_q.rx_cnt - CW'(1);
            else if (s_q.rx_idx != last_idx) begin
               s_d.rx_sh  = {s_q.rxd_sy[1], s_q.rx_sh[8:1]};
               s_d.rx_idx = s_q.rx_idx + 4'h1;
               s_d.rx_cnt = BIT_LAST;
            end else begin
               s_d.rx_data  = nine_bit ? s_q.rx_sh[7:0] : s_q.rx_sh[8:1];
               s_d.rx_flag  = nine_bit & s_q.rx_sh[8];  // R15
               s_d.rx_fe    = ~s_q.rxd_sy[1];
               s_d.rx_valid = 1'b1;
               s_d.rx_st    = udm_pkg::SER_IDLE;
            end
         end
         default: s_d.rx_st = udm_pkg::SER_IDLE;
      endcase

      unique case (s_q.tx_st)
         udm_pkg::SER_BITS: begin
            if (s_q.tx_cnt != '0)
               s_d.tx_cnt = s_q.tx_cnt - CW'(1);
            else begin
               s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
               if (s_q.tx_idx == last_idx + 4'h1)
                  s_d.tx_st = udm_pkg::SER_IDLE;
               else begin
                  s_d.tx_idx = s_q.tx_idx + 4'h1;
                  s_d.tx_cnt = BIT_LAST;
               end
            end
         end
         default: if (tx_valid && tx_ready) begin
            // Flag one marks an address
            s_d.tx_sh  = nine_bit ? {1'b1, tx_flag, tx_data, 1'b0} :
                                    {2'h3, tx_data, 1'b0};  // R14 R15 R18
            s_d.tx_st  = udm_pkg::SER_BITS;
            s_d.tx_idx = 4'h0;
            s_d.tx_cnt = BIT_LAST;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q           <= '0;
         s_q.tx_sh     <= '1;
         s_q.rxd_sy    <= '1;
         s_q.gate_sy   <= '1;
         s_q.op3_sy    <= '1;
         s_q.rts_n     <= 1'b1;
         s_q.cts_out_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.chan_a_serial_input   = s_q.tx_sh[0];
   assign link.input_pin_two         = s_q.rts_n;
   assign link.chan_a_clear_to_send_n = s_q.cts_out_n;
   assign rx_data                    = s_q.rx_data;
   assign rx_flag                    = s_q.rx_flag;
   assign rx_frame_err               = s_q.rx_fe;
   assign rx_valid                   = s_q.rx_valid;
   assign cts_in_n                   = s_q.op3_sy[1];
endmodule

// file: bench/udm_link_asserts.sv
// Link checks
`timescale 1ns/10ps
module udm_link_asserts (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic dev_serial_out,
   input wire logic chan_a_serial_input,
   input wire logic chan_a_request_to_send_n,
   input wire logic output_pin_three_n,
   input wire logic input_pin_two,
   input wire logic chan_a_clear_to_send_n
);
   logic [7:0] low_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         low_q <= 8'h00;
      else
         low_q <= dev_serial_out ? 8'h00 : low_q + 8'h01;
   a_dev_hold: assert property ($changed(dev_serial_out) |=>
      $stable(dev_serial_out)[*3]) else $error("tx bit short");
   a_peer_hold: assert property ($changed(chan_a_serial_input) |=>
      $stable(chan_a_serial_input)[*3]) else $error("rx bit short");
   a_low_run: assert property (low_q <= 8'h28)
      else $error("tx low too long");
   a_peer_start: assert property ($fell(chan_a_serial_input) |->
      !chan_a_serial_input[*4]) else $error("rx start short");
   a_rst_negated: assert property ($rose(arst_n) |->
      chan_a_request_to_send_n && output_pin_three_n) else $error("rts out active");
   a_rst_peer: assert property ($rose(arst_n) |-> input_pin_two &&
      chan_a_clear_to_send_n && dev_serial_out && chan_a_serial_input) else $error("idle bad");
   a_cts_gate: assert property ($fell(dev_serial_out) |->
      $past(!chan_a_clear_to_send_n, 3)) else $error("sent without cts");
   a_rts_tx_idle: assert property ($rose(chan_a_request_to_send_n) |->
      dev_serial_out && $past(dev_serial_out, 4)) else $error("rts dropped early");
endmodule

// file: bench/test_uart_flow_control_multidrop.sv
// Bench joining both ends
`timescale 1ns/10ps
module test_uart_flow_control_multidrop;
   logic        core_clk, arst_n, ren, wen, wrq, rx_fifo_full_flag;
   logic        nine, gate, rts_a, cts_a, txf, txv, txr, rxf, rxfe, rxv, ctsin;
   logic [5:0]  adr;
   logic [31:0] wdat, rdat;
   logic [7:0]  txd, rxd, q, d [4];
   int          n_fail, n_compared, seed, i, k;
   udm_link_if link ();
   wire         rts_n = link.chan_a_request_to_send_n;
   udm_duart_end #(.BIT_CYCLES(4)) u_udm_duart_end (.core_clk(core_clk), .arst_n(arst_n),
      .link(link), .avs_address(adr), .avs_read(ren), .avs_write(wen), .avs_writedata(wdat),
      .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wrq), .rx_fifo_full(rx_fifo_full_flag));
   udm_peer_end #(.BIT_CYCLES(4)) u_udm_peer_end (.core_clk(core_clk), .arst_n(arst_n),
      .link(link), .nine_bit(nine), .cts_gate_en(gate), .rts_assert(rts_a),
      .cts_out_assert(cts_a), .tx_data(txd), .tx_flag(txf), .tx_valid(txv), .tx_ready(txr),
      .rx_data(rxd), .rx_flag(rxf), .rx_frame_err(rxfe), .rx_valid(rxv), .cts_in_n(ctsin));
   udm_link_asserts u_udm_link_asserts (.core_clk(core_clk), .arst_n(arst_n),
      .dev_serial_out(link.dev_serial_out), .chan_a_serial_input(link.chan_a_serial_input),
      .chan_a_request_to_send_n(link.chan_a_request_to_send_n), .input_pin_two(link.input_pin_two),
      .output_pin_three_n(link.output_pin_three_n), .chan_a_clear_to_send_n(link.chan_a_clear_to_send_n));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [7:0] m1(input logic [1:0] p, input logic s, r);
      return {r, 2'h0, p, s, 2'h3};
   endfunction
   task end_of_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task tmo;
      n_fail++;
      $display("BAD wait expected done seen timeout");
      end_of_test();
   endtask
   task chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [7:0] dd = 8'h00);
      int j;
      @(posedge core_clk);
      {adr, wdat, wen, ren} <= {a, 2'h0, 24'h0, dd, w, ~w};
      for (j = 0; j < 50; j++) begin
         @(posedge core_clk);
         if (wrq === 1'b0) break;
      end
      if (j == 50) tmo();
      q = rdat[7:0];
      {wen, ren} <= 2'h0;
      @(negedge core_clk);
   endtask
   task poll(input logic [3:0] a, input logic [7:0] m, v);
      int j;
      j = 0;
      do begin
         bus(0, a);
         j++;
      end while (j < 200 && (q & m) !== v);
      chk("poll", v, q & m);
      if (j == 200) tmo();
   endtask
   task snd(input logic [7:0] dd, input logic f);
      int j;
      @(posedge core_clk);
      {txd, txf, txv} <= {dd, f, 1'b1};
      for (j = 0; j < 3000; j++) begin
         @(posedge core_clk);
         if (txr === 1'b1) break;
      end
      if (j == 3000) tmo();
      txv <= 1'b0;
   endtask
   initial begin
      {seed, n_fail, n_compared, arst_n, ren, wen, adr, wdat, txd} = {32'd36, 64'h0, 49'h0};
      {nine, gate, rts_a, cts_a, txf, txv} = 6'h00;
      repeat (10) @(posedge core_clk);
      {arst_n, gate} <= 2'h3;
      bus(1, udm_pkg::REG_MODE_ONE, m1(udm_pkg::PAR_NONE, 1'b0, 1'b1));
      bus(1, udm_pkg::REG_COMMAND, 8'h01);
      bus(1, udm_pkg::REG_OP_SET, 8'h01);
      chk("rts", 0, rts_n);
      for (i = 0; i < 4; i++)
         d[i] = 8'($random(seed));
      snd(d[0], 1'b0);
      poll(udm_pkg::REG_STATUS, 8'h01, 8'h01);
      snd(d[1], 1'b0);
      snd(d[2], 1'b0);
      poll(udm_pkg::REG_STATUS, 8'h72, 8'h02);
      chk("full", 1, rx_fifo_full_flag);
      chk("rts", 1, rts_n);
      for (i = 0; i < 3; i++) begin
         bus(0, udm_pkg::REG_RX_DATA);
         chk("rx", d[i], q);
         bus(0, udm_pkg::REG_STATUS);
         chk("status", 8'(i < 2), q & 8'h73);
      end
      chk("rts", 1, rts_n);
      bus(1, udm_pkg::REG_OP_SET, 8'h01);
      chk("rts", 0, rts_n);
      bus(1, udm_pkg::REG_OP_CLR, 8'h01);
      chk("rts", 1, rts_n);
      bus(0, 4'h9);
      chk("unmapped", 0, q);
      $display("receive test done");
      @(posedge core_clk) rts_a <= 1'b1;
      poll(udm_pkg::REG_IN_CHG, 8'h44, 8'h40);
      bus(1, udm_pkg::REG_OP_SET, 8'h08);
      chk("cts_out", 0, link.output_pin_three_n);
      bus(0, udm_pkg::REG_IN_CHG);
      chk("in_chg", 0, q & 8'h44);
      chk("cts_in", 0, ctsin);
      @(posedge core_clk) rts_a <= 1'b0;
      poll(udm_pkg::REG_IN_CHG, 8'h44, 8'h44);
      bus(1, udm_pkg::REG_OP_CLR, 8'h08);
      chk("cts_out", 1, link.output_pin_three_n);
      $display("input change test done");
      @(posedge core_clk) {nine, gate} <= 2'h2;
      bus(1, udm_pkg::REG_MODE_ONE, m1(udm_pkg::PAR_MULTI, 1'b0, 1'b0));
      bus(1, udm_pkg::REG_COMMAND, 8'h00);
      for (i = 0; i < 4; i++)
         snd(d[i], ~i[0]);
      for (i = 0; i < 2; i++) begin
         bus(0, udm_pkg::REG_STATUS);
         chk("md_status", 8'h21, q & 8'h21);
         bus(0, udm_pkg::REG_RX_DATA);
         chk("md_rx", d[2*i], q);
      end
      $display("multidrop receive test done");
      bus(1, udm_pkg::REG_MODE_TWO, 8'h30);
      bus(1, udm_pkg::REG_COMMAND, 8'h02);
      for (i = 0; i < 2; i++) begin
         bus(1, udm_pkg::REG_MODE_ONE, m1(udm_pkg::PAR_MULTI, i[0], 1'b0));
         bus(1, udm_pkg::REG_OP_SET, 8'h01);
         bus(1, udm_pkg::REG_TX_DATA, d[i]);
         repeat (12) @(negedge core_clk);
         chk("held", 1, link.dev_serial_out);
         @(posedge core_clk) cts_a <= 1'b1;
         for (k = 0; k < 400 && rxv !== 1'b1; k++)
            @(negedge core_clk);
         if (k == 400) tmo();
         chk("tx", {1'b0, i[0], d[i]}, {rxfe, rxf, rxd});
         chk("rts_hold", 0, rts_n);
         for (k = 0; k < 40 && rts_n !== 1'b1; k++)
            @(negedge core_clk);
         chk("rts_drop", 1, rts_n);
         @(posedge core_clk);
         cts_a <= 1'b0;
      end
      $display("transmit test done");
      end_of_test();
   end
endmodule
